/* File: design/pmx_pkg.sv */
/*
  Package of the port pin function multiplexer: register offsets,
  write masks, reset values, function codes and the APB request carrier.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
package pmx_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_A_DIR   = 8'h00;
  localparam logic [7:0] OFF_A_FN1   = 8'h04;
  localparam logic [7:0] OFF_A_FN2   = 8'h08;
  localparam logic [7:0] OFF_D_DIR   = 8'h0c;
  localparam logic [7:0] OFF_D_FN    = 8'h10;
  localparam logic [7:0] OFF_E_DIR   = 8'h14;
  localparam logic [7:0] OFF_E_FN_LO = 8'h18;
  localparam logic [7:0] OFF_E_FN_HI = 8'h1c;
  // Writable bits; reserved positions are dropped on write
  localparam logic [15:0] A_DIR_MASK = 16'h03ff;
  localparam logic [15:0] A_FN1_MASK = 16'h0005;
  localparam logic [15:0] A_FN2_MASK = 16'h5555;
  localparam logic [15:0] A_DIR_RST  = 16'h0000;
  localparam logic [15:0] A_FN_RST   = 16'h0000;
  // Port E function fields, two bits per pin, pins 0..24
  localparam logic [49:0] E_FN_RST   = 50'h0_0000_0000_0040;
  localparam logic [49:0] E_FN_HOST  = 50'h1_5555_5555_5555;
  localparam int unsigned E_BOOT_PIN = 3;
  // Cycles after reset release until the strap has crossed the synchroniser
  localparam logic [1:0] BOOT_WAIT   = 2'h2;
  localparam logic [1:0] BOOT_DONE   = 2'h3;
  // Per-pin function codes
  typedef enum logic [1:0] {
    FN_GPIO = 2'h0,
    FN_ALT2 = 2'h1,
    FN_ALT3 = 2'h2
  } pmx_fn_e;
  // APB request signals from the master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } pmx_apb_s;
endpackage

/* File: design/pmx_top.sv */
/*
  Pin function multiplexer for general ports A (pins 16..25), D and E,
  with its APB register file. Pads are split into in/out/enable; the pad
  ring resolves the wire. Peripheral units sit on sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module pmx_top (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // APB slave
  input  wire pmx_pkg::pmx_apb_s apb_i,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Port A pads and users
  input  wire logic [9:0]       pa_in,
  output logic [9:0]            pa_out,
  output logic [9:0]            pa_oe,
  input  wire logic [9:0]       pa_gpio_o,
  output logic [9:0]            pa_gpio_i,
  input  wire logic [9:0]       bus_addr_line,
  // Port D pads and users
  input  wire logic [7:0]       pd_in,
  output logic [7:0]            pd_out,
  output logic [7:0]            pd_oe,
  input  wire logic [7:0]       pd_gpio_o,
  output logic [7:0]            pd_gpio_i,
  output logic [7:0]            ext_int_req,
  // Port E pads and users
  input  wire logic [24:0]      pe_in,
  output logic [24:0]           pe_out,
  output logic [24:0]           pe_oe,
  input  wire logic [24:0]      pe_gpio_o,
  output logic [24:0]           pe_gpio_i,
  // Host port unit
  input  wire logic             host_ready_out,
  input  wire logic             host_transfer_req_out,
  input  wire logic             host_irq_out,
  input  wire logic             host_ctl_oe,
  input  wire logic [15:0]      host_data_o,
  input  wire logic             host_data_oe,
  output logic [15:0]           host_data_i,
  output logic                  host_buffer_enable_in,
  output logic                  host_boot_select_in,
  output logic                  host_read_strobe_in,
  output logic                  host_write_strobe_in,
  output logic                  host_reg_select_in,
  output logic                  host_chip_select_in,
  // Serial units, index 0..2
  input  wire logic [2:0]       serial_tx,
  input  wire logic [2:0]       serial_clk_o,
  input  wire logic [2:0]       serial_clk_oe,
  input  wire logic [1:0]       serial_req_send,
  output logic [2:0]            serial_rx,
  output logic [2:0]            serial_clk_i,
  output logic [1:0]            serial_clear_send
);
  logic [15:0] pa_dir_q, pa_fn1_q, pa_fn2_q, pd_fn_q;
  logic [7:0]  pd_dir_q, addr;
  logic [24:0] pe_dir_q;
  logic [49:0] pe_fn_q;
  logic [42:0] pad_meta_q, pad_sync_q;
  logic [9:0]  a_s;
  logic [7:0]  d_s;
  logic [24:0] e_s;
  logic [1:0]  boot_cnt_q;
  logic        boot_load, acc, wr_en;
  logic [31:0] wd;

  // Pin drive: general port uses its direction bit, alternates their own enable
  // direction or selected function
  function automatic logic [1:0] drive(input logic [1:0] fn, input logic go, gdir,
                                       a2o, a2oe, a3o, a3oe);
    unique case (fn)
      pmx_pkg::FN_ALT2: drive = {a2oe, a2o};
      pmx_pkg::FN_ALT3: drive = {a3oe, a3o};
      default:          drive = {gdir, go};
    endcase
  endfunction

  // Pad inputs cross two flops before any logic looks at them
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {pad_meta_q, pad_sync_q} <= '0;
    end else begin
      pad_meta_q <= {pe_in, pd_in, pa_in};
      pad_sync_q <= pad_meta_q;
    end
  end
  assign a_s = pad_sync_q[9:0];
  assign d_s = pad_sync_q[17:10];
  assign e_s = pad_sync_q[42:18];
  assign pa_gpio_i = a_s;
  assign pd_gpio_i = d_s;
  assign pe_gpio_i = e_s;

  // APB: pready is registered, so every access phase lasts two cycles
  assign addr  = apb_i.paddr;
  assign wd    = apb_i.pwdata;
  assign acc   = apb_i.psel & apb_i.penable;
  assign wr_en = acc & pready & apb_i.pwrite;

  // Read decode; unmapped offsets read zero
  function automatic logic [32:0] rd_word(input logic [7:0] a);
    rd_word = '0;
    unique case (a)
      pmx_pkg::OFF_A_DIR:   rd_word = {17'h00000, pa_dir_q};
      pmx_pkg::OFF_A_FN1:   rd_word = {17'h00000, pa_fn1_q};
      pmx_pkg::OFF_A_FN2:   rd_word = {17'h00000, pa_fn2_q};
      pmx_pkg::OFF_D_DIR:   rd_word = {25'h0000000, pd_dir_q};
      pmx_pkg::OFF_D_FN:    rd_word = {17'h00000, pd_fn_q};
      pmx_pkg::OFF_E_DIR:   rd_word = {8'h00, pe_dir_q};
      pmx_pkg::OFF_E_FN_LO: rd_word = {1'b0, pe_fn_q[31:0]};
      pmx_pkg::OFF_E_FN_HI: rd_word = {15'h0000, pe_fn_q[49:32]};
      default:              rd_word = {1'b1, 32'h00000000};
    endcase
  endfunction

  // Bus answer, one wait state
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {pready, prdata, pslverr} <= '0;
    end else begin
      pready <= acc & ~pready;
      if (acc & ~pready) begin
        {pslverr, prdata} <= rd_word(addr);
      end
    end
  end

  // Ports A and D configuration registers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pa_dir_q <= pmx_pkg::A_DIR_RST;
      pa_fn1_q <= pmx_pkg::A_FN_RST;
      pa_fn2_q <= pmx_pkg::A_FN_RST;
      {pd_dir_q, pd_fn_q} <= '0;
    end else if (wr_en) begin
      unique case (addr)
        pmx_pkg::OFF_A_DIR: pa_dir_q <= wd[15:0] & pmx_pkg::A_DIR_MASK;
        pmx_pkg::OFF_A_FN1: pa_fn1_q <= wd[15:0] & pmx_pkg::A_FN1_MASK;
        pmx_pkg::OFF_A_FN2: pa_fn2_q <= wd[15:0] & pmx_pkg::A_FN2_MASK;
        pmx_pkg::OFF_D_DIR: pd_dir_q <= wd[7:0];
        pmx_pkg::OFF_D_FN:  pd_fn_q  <= wd[15:0];
        default: ;
      endcase
    end
  end

  // Boot strap sampled once it has crossed the synchroniser
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      boot_cnt_q <= '0;
    end else if (boot_cnt_q != pmx_pkg::BOOT_DONE) begin
      boot_cnt_q <= boot_cnt_q + 2'h1;
    end
  end
  assign boot_load = (boot_cnt_q == pmx_pkg::BOOT_WAIT);

  // Port E registers; the boot load wins over a bus write
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // boot select pin starts in host role
      pe_fn_q  <= pmx_pkg::E_FN_RST;
      pe_dir_q <= '0;
    end else if (boot_load) begin
      if (e_s[pmx_pkg::E_BOOT_PIN]) begin
        pe_fn_q <= pmx_pkg::E_FN_HOST;
      end
    end else if (wr_en) begin
      unique case (addr)
        pmx_pkg::OFF_E_DIR:   pe_dir_q <= wd[24:0];
        pmx_pkg::OFF_E_FN_LO: pe_fn_q[31:0] <= wd;
        pmx_pkg::OFF_E_FN_HI: pe_fn_q[49:32] <= wd[17:0];
        default: ;
      endcase
    end
  end

  // Pin drive vectors, registered below so a select change is glitch free
  logic [9:0]  a_o, a_oe;
  logic [7:0]  d_o, d_oe, d3o, d3oe;
  logic [24:0] e_o, e_oe, e2o, e2oe, e3o, e3oe;
  logic [9:0]  a_sel;

  assign d3o  = {serial_clk_o[2], 1'b0, serial_tx[2],
                 serial_clk_o[1], 1'b0, serial_tx[1], 2'b00};
  assign d3oe = {serial_clk_oe[2], 1'b0, 1'b1, serial_clk_oe[1], 1'b0, 1'b1, 2'b00};
  // host control outputs; host data bits
  assign e2o  = {host_data_o, 4'h0, host_irq_out, 1'b0,
                 host_transfer_req_out, host_ready_out, 1'b0};
  assign e2oe = {{16{host_data_oe}}, 4'h0, host_ctl_oe, 1'b0, {2{host_ctl_oe}}, 1'b0};
  assign e3o  = {1'b0, serial_req_send[1], 1'b0, serial_req_send[0], serial_clk_o[1],
                 1'b0, serial_tx[1], serial_clk_o[0], 1'b0, serial_tx[0], 15'h0000};
  assign e3oe = {1'b0, 1'b1, 1'b0, 1'b1, serial_clk_oe[1], 1'b0, 1'b1,
                 serial_clk_oe[0], 1'b0, 1'b1, 15'h0000};

  genvar gi;
  generate
    for (gi = 0; gi < 10; gi++) begin : g_pa
      // pins 16..23 from even bits; pins 24 and 25
      if (gi < 8) begin : g_lo
        assign a_sel[gi] = pa_fn2_q[2*gi];
      end else begin : g_hi
        assign a_sel[gi] = pa_fn1_q[2*(gi-8)];
      end
      // direction ignored under the address function
      assign {a_oe[gi], a_o[gi]} = drive(a_sel[gi] ? pmx_pkg::FN_ALT2 : pmx_pkg::FN_GPIO,
                                         pa_gpio_o[gi], pa_dir_q[gi],
                                         bus_addr_line[gi], 1'b1, 1'b0, 1'b0);
    end
    for (gi = 0; gi < 8; gi++) begin : g_pd
      assign {d_oe[gi], d_o[gi]} = drive(pd_fn_q[2*gi+:2], pd_gpio_o[gi], pd_dir_q[gi],
                                         1'b0, 1'b0, d3o[gi], d3oe[gi]);
    end
    for (gi = 0; gi < 25; gi++) begin : g_pe
      assign {e_oe[gi], e_o[gi]} = drive(pe_fn_q[2*gi+:2], pe_gpio_o[gi], pe_dir_q[gi],
                                         e2o[gi], e2oe[gi], e3o[gi], e3oe[gi]);
    end
  endgenerate

  // pad drivers follow the registers one edge later
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {pa_out, pa_oe, pd_out, pd_oe, pe_out, pe_oe} <= '0;
    end else begin
      {pa_out, pa_oe, pd_out, pd_oe, pe_out, pe_oe} <= {a_o, a_oe, d_o, d_oe, e_o, e_oe};
    end
  end

  // Input routing; an unselected function sees zero
  logic [7:0]  d_f2, d_f3;
  logic [24:0] e_f2, e_f3;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_dsel
      assign d_f2[gi] = (pd_fn_q[2*gi+:2] == pmx_pkg::FN_ALT2);
      assign d_f3[gi] = (pd_fn_q[2*gi+:2] == pmx_pkg::FN_ALT3);
    end
    for (gi = 0; gi < 25; gi++) begin : g_esel
      assign e_f2[gi] = (pe_fn_q[2*gi+:2] == pmx_pkg::FN_ALT2);
      assign e_f3[gi] = (pe_fn_q[2*gi+:2] == pmx_pkg::FN_ALT3);
    end
  endgenerate

  // Serial 1 may sit on D and E at once; the two are ORed, so pick one
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {ext_int_req, serial_rx, serial_clk_i, serial_clear_send, host_data_i,
       host_chip_select_in, host_reg_select_in, host_write_strobe_in,
       host_read_strobe_in, host_boot_select_in, host_buffer_enable_in} <= '0;
    end else begin
      ext_int_req  <= d_s & d_f2;
      serial_rx    <= {d_s[6] & d_f3[6],
                       (d_s[3] & d_f3[3]) | (e_s[19] & e_f3[19]), e_s[16] & e_f3[16]};
      serial_clk_i <= {d_s[7] & d_f3[7],
                       (d_s[4] & d_f3[4]) | (e_s[20] & e_f3[20]), e_s[17] & e_f3[17]};
      serial_clear_send <= {e_s[24] & e_f3[24], e_s[22] & e_f3[22]};
      host_data_i  <= e_s[24:9] & e_f2[24:9];
      {host_chip_select_in, host_reg_select_in, host_write_strobe_in,
       host_read_strobe_in} <= e_s[8:5] & e_f2[8:5];
      host_boot_select_in   <= e_s[3] & e_f2[3];
      host_buffer_enable_in <= e_s[0] & e_f2[0];
    end
  end

  // Checks
  sequence s_wr(logic [7:0] off);
    wr_en && addr == off;
  endsequence

  a_pin25_addr: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pa_fn1_q[2] |=> pa_oe[9] && pa_out[9] == $past(bus_addr_line[9]))
    else $error("pin 25 not driving address");
  a_pin24_dir: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !pa_fn1_q[0] |=> pa_oe[8] == $past(pa_dir_q[8]))
    else $error("pin 24 direction not applied");
  a_dir_resv: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pready && acc && !apb_i.pwrite && addr == pmx_pkg::OFF_A_DIR |-> prdata[31:10] == '0)
    else $error("direction reserved bits read nonzero");
  a_fn1_resv: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_wr(pmx_pkg::OFF_A_FN1) |=> pa_fn1_q == ($past(wd[15:0]) & pmx_pkg::A_FN1_MASK))
    else $error("function register reserved bits kept");
  a_start_gpio: assert property (@(posedge sys_clk) disable iff (sys_rst)
    boot_cnt_q == 2'h1 |-> pa_oe == '0 && pd_oe == '0 && pa_fn2_q == '0)
    else $error("ports A or D not general after reset");
  a_boot_host: assert property (@(posedge sys_clk) disable iff (sys_rst)
    boot_load && e_s[3] |=> pe_fn_q == pmx_pkg::E_FN_HOST)
    else $error("host boot did not select host functions");
  a_boot_sel: assert property (@(posedge sys_clk) disable iff (sys_rst)
    boot_load && !e_s[3] |=> pe_fn_q == pmx_pkg::E_FN_RST)
    else $error("normal boot port E start wrong");
  a_data_order: assert property (@(posedge sys_clk) disable iff (sys_rst)
    e_f2[9] ##0 e_f2[9] [*2] |-> pe_out[9] == $past(host_data_o[0]))
    else $error("host data bit 0 not on pin 9");
  a_dfn_apply: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_wr(pmx_pkg::OFF_D_FN) ##1 (pd_fn_q[1:0] == pmx_pkg::FN_ALT2) |=> !pd_oe[0])
    else $error("function change not applied next edge");
endmodule
`default_nettype wire

/* File: design/unused_placeholder_none.sv */
/*
  Intentionally empty companion: no further logic; all logic is in pmx_top.
  Assumes nothing.
*/

/* File: sim/pmx_bench.sv */
/*
  Self-checking bench of the pin function multiplexer: APB master,
  register model, random pad and unit stimulus, compares at every result.
  Assumes pmx_pkg and pmx_top are compiled first; single 200 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module pmx_bench;
  logic              sys_clk, sys_rst, pready, pslverr, err;
  pmx_pkg::pmx_apb_s apb_i;
  logic [31:0]       prdata, rng, rd, regm [8];
  logic [9:0]        pa_in, pa_out, pa_oe, pa_gpio_o, pa_gpio_i, bus_addr_line, alt, eo;
  logic [7:0]        pd_in, pd_out, pd_oe, pd_gpio_o, pd_gpio_i, ext_int_req;
  logic [24:0]       pe_in, pe_out, pe_oe, pe_gpio_o, pe_gpio_i;
  logic              host_ready_out, host_transfer_req_out, host_irq_out, host_ctl_oe;
  logic [15:0]       host_data_o, host_data_i;
  logic              host_data_oe, host_buffer_enable_in, host_boot_select_in;
  logic              host_read_strobe_in, host_write_strobe_in;
  logic              host_reg_select_in, host_chip_select_in;
  logic [2:0]        serial_tx, serial_clk_o, serial_clk_oe, serial_rx, serial_clk_i;
  logic [1:0]        serial_req_send, serial_clear_send;
  int unsigned       errors, comparisons;
  // Writable bits of each register, index = byte offset / 4
  localparam logic [31:0] MASKS [8] = '{32'h3ff, 32'h5, 32'h5555, 32'hff, 32'hffff,
                                        32'h1ffffff, 32'hffffffff, 32'h3ffff};

  pmx_top u_dut (.sys_clk, .sys_rst, .apb_i, .prdata, .pready, .pslverr,
    .pa_in, .pa_out, .pa_oe, .pa_gpio_o, .pa_gpio_i, .bus_addr_line,
    .pd_in, .pd_out, .pd_oe, .pd_gpio_o, .pd_gpio_i, .ext_int_req,
    .pe_in, .pe_out, .pe_oe, .pe_gpio_o, .pe_gpio_i,
    .host_ready_out, .host_transfer_req_out, .host_irq_out, .host_ctl_oe,
    .host_data_o, .host_data_oe, .host_data_i, .host_buffer_enable_in,
    .host_boot_select_in, .host_read_strobe_in, .host_write_strobe_in,
    .host_reg_select_in, .host_chip_select_in, .serial_tx, .serial_clk_o,
    .serial_clk_oe, .serial_req_send, .serial_rx, .serial_clk_i, .serial_clear_send);

  // Clock, 5 ns period
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Xorshift source, fixed seed for repeatable runs
  function automatic logic [31:0] nxt();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge sys_clk);
    apb_i.penable <= 1'b1;
    // Only the watchdog ends a wait that never sees ready
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb_i <= '0;
  endtask

  task automatic wreg(input int i, input logic [31:0] d);
    if (i < 2) d &= MASKS[i]; // software writes zero to reserved bits of registers 0 and 1
    apb(1'b1, 8'(i * 4), d);
    regm[i] = d & MASKS[i];
    chk(32'(err), 32'h0, "write error");
  endtask

  task automatic rreg(input int i);
    apb(1'b0, 8'(i * 4), 32'h0);
    chk(rd, regm[i], "read value");
    chk(32'(err), 32'h0, "read error");
  endtask

  // New random pad and unit levels, then let the 3-edge input path settle
  task automatic stim();
    @(posedge sys_clk);
    pa_in <= 10'(nxt());
    pd_in <= 8'(nxt());
    pe_in <= 25'(nxt());
    pa_gpio_o <= 10'(nxt());
    pd_gpio_o <= 8'(nxt());
    pe_gpio_o <= 25'(nxt());
    bus_addr_line <= 10'(nxt());
    {host_ready_out, host_transfer_req_out, host_irq_out, host_ctl_oe} <= 4'(nxt());
    host_data_o <= 16'(nxt());
    host_data_oe <= 1'(nxt());
    serial_tx <= 3'(nxt());
    serial_clk_o <= 3'(nxt());
    serial_clk_oe <= 3'(nxt());
    serial_req_send <= 2'(nxt());
    repeat (5) @(posedge sys_clk);
    #1;
  endtask

  // Reset with the boot strap on port E pin 3 held through the boot load
  task automatic do_reset(input logic boot);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    pe_in[3] <= boot;
    apb_i <= '0;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    foreach (regm[i]) regm[i] = 32'h0;
    regm[6] = boot ? pmx_pkg::E_FN_HOST[31:0] : 32'h40;
    regm[7] = boot ? 32'(pmx_pkg::E_FN_HOST[49:32]) : 32'h0;
  endtask

  task automatic wrap_up();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog, well beyond the roughly 500 cycles the sequence needs
  initial begin
    #100000;
    errors++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    wrap_up();
  end

  // Main sequence
  initial begin
    rng = 32'h637b2571;
    errors = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    apb_i = '0;
    {pa_in, pa_gpio_o, bus_addr_line, pd_in, pd_gpio_o, pe_in, pe_gpio_o} = '0;
    {host_ready_out, host_transfer_req_out, host_irq_out, host_ctl_oe} = '0;
    {host_data_o, host_data_oe, serial_tx, serial_clk_o, serial_clk_oe} = '0;
    serial_req_send = '0;
    do_reset(1'b0);
    for (int i = 0; i < 8; i++) rreg(i);
    chk(32'(pa_oe), 32'h0, "port A starts as inputs");
    // Unmapped offset is refused on write and reads zero with an error
    apb(1'b1, 8'h20, 32'hffffffff);
    chk(32'(err), 32'h1, "unmapped write");
    apb(1'b0, 8'h20, 32'h0);
    chk({rd[31:1], err}, 32'h1, "unmapped read");
    for (int i = 0; i < 3; i++) begin
      wreg(i, 32'hffffffff);
      rreg(i);
    end
    // Direction reaches the pads one edge after the register
    wreg(1, 32'h0);
    wreg(2, 32'h0);
    wreg(0, 32'h0);
    stim();
    wreg(0, 32'h3ff);
    #1 chk(32'(pa_oe), 32'h0, "pad enable too early");
    @(posedge sys_clk);
    #1 chk(32'(pa_oe), 32'h3ff, "pad enable late");
    // Port A random direction and function mixes
    repeat (8) begin
      wreg(0, nxt());
      wreg(1, nxt());
      wreg(2, nxt());
      stim();
      for (int j = 0; j < 10; j++) alt[j] = (j < 8) ? regm[2][2*j] : regm[1][2*(j-8)];
      eo = alt | regm[0][9:0];
      chk(32'(pa_oe), 32'(eo), "port A enable");
      chk(32'(pa_out & eo), 32'(((alt & bus_addr_line) | (~alt & pa_gpio_o)) & eo),
          "port A drive");
      chk(32'(pa_gpio_i), 32'(pa_in), "port A input");
    end
    // Port D interrupt inputs, then serial third function
    wreg(3, 32'hff);
    wreg(4, 32'h5555);
    stim();
    chk(32'({ext_int_req, pd_oe}), 32'({pd_in, 8'h0}), "interrupt route");
    chk(32'(pd_gpio_i), 32'(pd_in), "port D input");
    wreg(4, 32'haaa0);
    stim();
    chk(32'(ext_int_req), 32'h0, "interrupt off");
    chk(32'({pd_oe[5], pd_oe[2], pd_out[5], pd_out[2], serial_rx[2:1]}),
        32'({2'b11, serial_tx[2:1], pd_in[6], pd_in[3]}), "port D serial");
    chk(32'({pd_oe[7:2], serial_clk_i[2:1]}), 32'({serial_clk_oe[2], 2'b01, serial_clk_oe[1],
        2'b01, pd_in[7], pd_in[4]}), "port D serial clock");
    chk(32'({pd_out[7], pd_out[4]} & serial_clk_oe[2:1]),
        32'(serial_clk_o[2:1] & serial_clk_oe[2:1]), "port D clock out");
    chk(32'({pd_oe[1:0], pd_out[1:0]}), 32'({2'b11, pd_gpio_o[1:0]}), "port D general");
    // Code 11 falls back to the general port
    wreg(4, 32'hffff);
    stim();
    chk(32'({pd_oe, pd_out, ext_int_req}), 32'({8'hff, pd_gpio_o, 8'h0}), "port D code 11");
    // Port E host functions
    wreg(4, 32'h0);
    wreg(6, 32'h55555555);
    wreg(7, 32'h15555);
    stim();
    chk({pe_oe[24:9], pe_out[24:9] & {16{host_data_oe}}},
        {{16{host_data_oe}}, host_data_o & {16{host_data_oe}}}, "host data out");
    chk(32'(host_data_i), 32'(pe_in[24:9]), "host data in");
    chk(32'({pe_oe[4], pe_oe[2], pe_oe[1],
        {pe_out[4], pe_out[2], pe_out[1]} & {3{host_ctl_oe}}}),
        32'({{3{host_ctl_oe}}, {host_irq_out, host_transfer_req_out, host_ready_out}
        & {3{host_ctl_oe}}}), "host outputs");
    chk(32'({host_chip_select_in, host_reg_select_in, host_write_strobe_in,
        host_read_strobe_in, host_boot_select_in, host_buffer_enable_in}),
        32'({pe_in[8:5], pe_in[3], pe_in[0]}), "host inputs");
    // Port E serial third function
    wreg(6, 32'h80000040);
    wreg(7, 32'h2aaaa);
    stim();
    chk(32'({pe_out[23], pe_out[21], pe_out[18], pe_out[15]}),
        32'({serial_req_send, serial_tx[1:0]}), "port E serial out");
    chk(32'({serial_clear_send, serial_rx[1:0], host_data_i, host_boot_select_in}),
        32'({pe_in[24], pe_in[22], pe_in[19], pe_in[16], 16'h0, pe_in[3]}),
        "port E serial in");
    chk(32'({pe_oe[24:15], serial_clk_i[1:0]}), 32'({4'b0101, serial_clk_oe[1], 2'b01,
        serial_clk_oe[0], 2'b01, pe_in[20], pe_in[17]}), "port E serial enables");
    chk(32'({pe_out[20], pe_out[17]} & serial_clk_oe[1:0]),
        32'(serial_clk_o[1:0] & serial_clk_oe[1:0]), "port E clock out");
    chk(32'(pe_gpio_i), 32'(pe_in), "port E input");
    // Host boot: second reset in mid-run with the strap high
    do_reset(1'b1);
    for (int i = 0; i < 8; i++) rreg(i);
    wreg(6, 32'h0);
    rreg(6);
    stim();
    chk({31'h0, host_boot_select_in}, 32'h0, "strap pin released");
    // Random sweep of the whole map
    repeat (16) begin
      automatic int i = int'(nxt() % 8);
      wreg(i, nxt());
      rreg(i);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
